/* rtl/dpdm_detect.sv */
`timescale 1ns/100ps
module dpdm_detect (
   input  wire logic                     CLK,
   input  wire logic                     NRST,
   input  wire logic                     SOURCE_QUALIFIED,
   input  wire logic                     AUTO_DETECT_ENABLE,
   input  wire logic                     HV_ADAPTER_ENABLE,
   input  wire logic                     REQUEST_9V_ENABLE,
   input  wire logic                     REQUEST_12V_ENABLE,
   input  wire logic                     DETECT_COMPLETE_IRQ_MASK,
   input  wire logic                     DETECT_COMPLETE_FLAG_CLR,
   output logic                          DETECT_RUNNING_STATUS,
   output logic                          DETECT_COMPLETE_FLAG,
   output logic                          IRQ_N,
   output logic [3:0]                    SOURCE_TYPE_CODE,
   output logic [11:0]                   INPUT_CURRENT_LIMIT,
   input  wire logic                     ILIM_WR,
   input  wire logic [11:0]              ILIM_WDATA,
   output logic                          STAGE_REQ,
   output logic [2:0]                    STAGE_SEL,
   input  wire dpdm_pkg::dpdm_stage_type STAGE_RESULT,
   input  wire logic                     DRIVE_WR,
   input  wire logic [2:0]               DP_LEVEL_WDATA,
   input  wire logic [2:0]               DM_LEVEL_WDATA,
   output logic [2:0]                    DP_DRIVE_LEVEL,
   output logic [2:0]                    DM_DRIVE_LEVEL,
   input  wire logic [7:0]               DP_ADC_IN,
   input  wire logic [7:0]               DM_ADC_IN,
   output logic [7:0]                    DP_ADC_VALUE,
   output logic [7:0]                    DM_ADC_VALUE,
   input  wire logic                     POWER_ON_SENSE,
   input  wire logic                     FET_PAIR1_SENSE,
   input  wire logic                     FET_PAIR2_SENSE,
   output logic                          FET_PAIR1_PRESENT,
   output logic                          FET_PAIR2_PRESENT,
   input  wire logic                     FET_ENABLE_WR,
   input  wire logic [1:0]               FET_ENABLE_WDATA,
   output logic                          FET_PAIR1_ENABLE,
   output logic                          FET_PAIR2_ENABLE
);
   import dpdm_pkg::*;

   // ==========================================================
   // synchronisers for pin-derived inputs
   logic [1:0] qual_s, sense1_s, sense2_s, pon_s;
   logic [7:0] dpa_s1, dpa_s2, dma_s1, dma_s2;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         qual_s   <= 2'h0;
         sense1_s <= 2'h0;
         sense2_s <= 2'h0;
         pon_s    <= 2'h0;
         dpa_s1   <= 8'h00;
         dpa_s2   <= 8'h00;
         dma_s1   <= 8'h00;
         dma_s2   <= 8'h00;
      end else begin
         qual_s   <= {qual_s[0], SOURCE_QUALIFIED};
         sense1_s <= {sense1_s[0], FET_PAIR1_SENSE};
         sense2_s <= {sense2_s[0], FET_PAIR2_SENSE};
         pon_s    <= {pon_s[0], POWER_ON_SENSE};
         dpa_s1   <= DP_ADC_IN;
         dpa_s2   <= dpa_s1;
         dma_s1   <= DM_ADC_IN;
         dma_s2   <= dma_s1;
      end
   end
   wire qual  = qual_s[1];
   wire sense1 = sense1_s[1];
   wire sense2 = sense2_s[1];
   wire pon   = pon_s[1];

   // ==========================================================
   // state machine and watchdog
   dpdm_state_type   state_r, state_nxt;
   logic             qual_d_r;
   logic [CNT_W-1:0] cnt_r;
   logic             ddcp_r;
   logic [3:0]       type_r;
   logic [11:0]      ilim_r;
   logic             flag_r, irq_r;
   wire insert    = qual && !qual_d_r;
   wire start     = insert && AUTO_DETECT_ENABLE;
   wire timeout   = (cnt_r == CNT_W'(STAGE_CYC - 1));
   wire stage_end = STAGE_RESULT.done || timeout;
   wire hv_ok     = HV_ADAPTER_ENABLE && (REQUEST_9V_ENABLE || REQUEST_12V_ENABLE);
   wire running   = (state_r != ST_IDLE) && (state_r != ST_DONE);

   // divider class to limit
   function automatic logic [11:0] div_limit(input logic [2:0] c);
      case (c)
         PRI_DIV1: div_limit = ILIM_DIV1;
         PRI_DIV2: div_limit = ILIM_DIV2;
         PRI_DIV3: div_limit = ILIM_DIV3;
         default:  div_limit = ILIM_DIV4;
      endcase
   endfunction

   // next state: each stage waits for its result or the watchdog timeout
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (start) state_nxt = ST_DCD;
         ST_DCD:  if (stage_end) state_nxt = ST_PRI;
         ST_PRI:  if (stage_end) begin
            if (!timeout && STAGE_RESULT.cls == PRI_PORT) state_nxt = ST_SEC;
            else state_nxt = ST_DONE;
         end
         ST_SEC:  if (stage_end) begin
            if (!timeout && STAGE_RESULT.ok && hv_ok)
               state_nxt = REQUEST_12V_ENABLE ? ST_HV12 : ST_HV9;
            else state_nxt = ST_DONE;
         end
         ST_HV12: if (stage_end) begin
            if (!timeout && STAGE_RESULT.ok) state_nxt = ST_DONE;
            else if (REQUEST_9V_ENABLE) state_nxt = ST_HV9;
            else state_nxt = ST_DONE;
         end
         ST_HV9:  if (stage_end) state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
      if (insert && running) state_nxt = ST_DCD;
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_r  <= ST_IDLE;
         qual_d_r <= 1'b0;
         cnt_r    <= '0;
      end else begin
         state_r  <= state_nxt;
         qual_d_r <= qual;
         cnt_r    <= (state_nxt != state_r || !running) ? '0 : cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // result registers
   wire hv_pass = (state_r == ST_HV12 || state_r == ST_HV9) && stage_end && !timeout && STAGE_RESULT.ok;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         type_r <= TYPE_NONE;
         ilim_r <= ILIM_RST;
      end else if (state_r == ST_PRI && stage_end) begin
         case (timeout ? PRI_UNK : STAGE_RESULT.cls)
            PRI_SDP:  begin type_r <= TYPE_SDP; ilim_r <= ILIM_SDP; end
            PRI_PORT: ilim_r <= ilim_r;
            PRI_UNK:  begin type_r <= TYPE_UNK; ilim_r <= ILIM_UNK; end
            default:  begin type_r <= TYPE_NSTD; ilim_r <= div_limit(STAGE_RESULT.cls); end
         endcase
      end else if (state_r == ST_SEC && stage_end) begin
         if (!timeout && STAGE_RESULT.ok) begin
            type_r <= TYPE_DCP;
            ilim_r <= ILIM_DCP;
         end else begin
            type_r <= TYPE_CDP;
            ilim_r <= ILIM_CDP;
         end
      end else if (hv_pass) begin
         type_r <= TYPE_HV;
         ilim_r <= ILIM_HV;
      end else if (ILIM_WR && !running) begin
         ilim_r <= ILIM_WDATA;
      end
   end

   // ==========================================================
   // completion flag and active-low interrupt pulse
   wire finish = (state_r == ST_DONE);
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         flag_r <= 1'b0;
         irq_r  <= 1'b0;
      end else begin
         flag_r <= finish | (flag_r & ~DETECT_COMPLETE_FLAG_CLR);
         irq_r  <= finish & ~DETECT_COMPLETE_IRQ_MASK;
      end
   end

   // ==========================================================
   // drive levels, adc readback, fet pairs
   logic [2:0] dp_r, dm_r;
   logic [7:0] dpa_r, dma_r;
   logic       p1_r, p2_r, e1_r, e2_r, pon_d_r;
   wire drv_ok = DRIVE_WR && !(qual && running);
   wire pon_rise = pon && !pon_d_r;
   wire fet_ok = FET_ENABLE_WR && !(p1_r && p2_r && FET_ENABLE_WDATA == 2'h3);
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         dp_r    <= DRV_HIZ;
         dm_r    <= DRV_HIZ;
         dpa_r   <= 8'h00;
         dma_r   <= 8'h00;
         p1_r    <= 1'b0;
         p2_r    <= 1'b0;
         e1_r    <= 1'b0;
         e2_r    <= 1'b0;
         pon_d_r <= 1'b0;
      end else begin
         if (drv_ok) begin
            dp_r <= DP_LEVEL_WDATA;
            dm_r <= (DM_LEVEL_WDATA == DRV_0V || DM_LEVEL_WDATA == DRV_SHORT) ? DRV_HIZ : DM_LEVEL_WDATA;
         end
         dpa_r   <= dpa_s2;
         dma_r   <= dma_s2;
         pon_d_r <= pon;
         if (pon_rise) begin
            p1_r <= sense1;
            p2_r <= sense2;
         end
         if (fet_ok) begin
            e1_r <= FET_ENABLE_WDATA[0] & p1_r;
            e2_r <= FET_ENABLE_WDATA[1] & p2_r;
         end
      end
   end

   // ==========================================================
   // outputs; the stage port and drive pins are wired to input port one only
   assign DETECT_RUNNING_STATUS = running;
   assign DETECT_COMPLETE_FLAG  = flag_r;
   assign IRQ_N                 = ~irq_r;
   assign SOURCE_TYPE_CODE      = type_r;
   assign INPUT_CURRENT_LIMIT   = ilim_r;
   assign STAGE_REQ             = running;
   assign STAGE_SEL             = {state_r[4] | state_r[5], state_r[2] | state_r[3], state_r[1] | state_r[3] | state_r[5]};
   assign DP_DRIVE_LEVEL        = dp_r;
   assign DM_DRIVE_LEVEL        = dm_r;
   assign DP_ADC_VALUE          = dpa_r;
   assign DM_ADC_VALUE          = dma_r;
   assign FET_PAIR1_PRESENT     = p1_r;
   assign FET_PAIR2_PRESENT     = p2_r;
   assign FET_PAIR1_ENABLE      = e1_r;
   assign FET_PAIR2_ENABLE      = e2_r;

   // ==========================================================
   // checks
   a_irq_unmasked: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == ST_DONE && !DETECT_COMPLETE_IRQ_MASK) |=> !IRQ_N) else $error("irq missing");
   a_irq_masked: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == ST_DONE && DETECT_COMPLETE_IRQ_MASK) |=> IRQ_N) else $error("irq not masked");
   a_hv_order: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == ST_SEC && state_nxt == ST_HV9) |-> !REQUEST_12V_ENABLE) else $error("9v before 12v");
   a_hv_gate: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == ST_SEC && state_nxt[5:4] != 2'h0) |-> hv_ok) else $error("hv without enable");
   a_skip_auto: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == ST_IDLE && !AUTO_DETECT_ENABLE) |=> state_r == ST_IDLE) else $error("ran while disabled");
   a_level_lock: assert property (@(posedge CLK) disable iff (!NRST)
      (running && qual) |=> $stable(DP_DRIVE_LEVEL)) else $error("level changed during detection");
   a_dm_no_zero: assert property (@(posedge CLK) disable iff (!NRST)
      DM_DRIVE_LEVEL != DRV_0V) else $error("dm at 0v");
   a_fet_both: assert property (@(posedge CLK) disable iff (!NRST)
      (FET_PAIR1_PRESENT && FET_PAIR2_PRESENT) |-> !(FET_PAIR1_ENABLE && FET_PAIR2_ENABLE)) else $error("both fets on");
   a_dcp_limit: assert property (@(posedge CLK) disable iff (!NRST)
      (state_r == ST_SEC && stage_end && !timeout && STAGE_RESULT.ok) |=> INPUT_CURRENT_LIMIT == ILIM_DCP)
      else $error("dcp limit wrong");
   c_dcp: cover property (@(posedge CLK) state_r == ST_SEC ##1 state_r == ST_DONE);
   c_hv12: cover property (@(posedge CLK) state_r == ST_HV12 ##1 state_r == ST_DONE);
   c_div: cover property (@(posedge CLK) type_r == TYPE_NSTD);
endmodule // dpdm_detect

/* rtl/dpdm_pkg.sv */
package dpdm_pkg;
   // ==========================================================
   // source type codes
   localparam logic [3:0] TYPE_NONE = 4'h0;
   localparam logic [3:0] TYPE_SDP  = 4'h1;
   localparam logic [3:0] TYPE_CDP  = 4'h2;
   localparam logic [3:0] TYPE_DCP  = 4'h3;
   localparam logic [3:0] TYPE_HV   = 4'h4;
   localparam logic [3:0] TYPE_UNK  = 4'h5;
   localparam logic [3:0] TYPE_NSTD = 4'h6;

   // ==========================================================
   // current limits in mA
   localparam logic [11:0] ILIM_SDP  = 12'd500;
   localparam logic [11:0] ILIM_CDP  = 12'd1500;
   localparam logic [11:0] ILIM_DCP  = 12'd3250;
   localparam logic [11:0] ILIM_HV   = 12'd1500;
   localparam logic [11:0] ILIM_UNK  = 12'd3000;
   localparam logic [11:0] ILIM_DIV1 = 12'd2100;
   localparam logic [11:0] ILIM_DIV2 = 12'd2000;
   localparam logic [11:0] ILIM_DIV3 = 12'd1000;
   localparam logic [11:0] ILIM_DIV4 = 12'd2400;
   localparam logic [11:0] ILIM_RST  = 12'd3000;

   // ==========================================================
   // primary classification from the comparator front end
   localparam logic [2:0] PRI_SDP  = 3'h0;
   localparam logic [2:0] PRI_PORT = 3'h1;
   localparam logic [2:0] PRI_DIV1 = 3'h2;
   localparam logic [2:0] PRI_DIV2 = 3'h3;
   localparam logic [2:0] PRI_DIV3 = 3'h4;
   localparam logic [2:0] PRI_DIV4 = 3'h5;
   localparam logic [2:0] PRI_UNK  = 3'h6;

   // ==========================================================
   // drive level codes; dm code 1 (0 V) is not offered
   localparam logic [2:0] DRV_HIZ   = 3'h0;
   localparam logic [2:0] DRV_0V    = 3'h1;
   localparam logic [2:0] DRV_SHORT = 3'h7;

   // ==========================================================
   // timing
   localparam int CLK_MHZ      = 100;
   localparam int STAGE_US     = 40;
   localparam int STAGE_CYC    = STAGE_US * CLK_MHZ;
   localparam int CNT_W        = 13;

   // ==========================================================
   // analog stage handshake: one request, one result
   typedef struct packed {
      logic       done;
      logic       ok;
      logic [2:0] cls;
   } dpdm_stage_type;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_DCD  = 7'b0000010,
      ST_PRI  = 7'b0000100,
      ST_SEC  = 7'b0001000,
      ST_HV12 = 7'b0010000,
      ST_HV9  = 7'b0100000,
      ST_DONE = 7'b1000000
   } dpdm_state_type;
endpackage

/* testbench/dpdm_stage_model.sv */
`timescale 1ns/100ps
// ==========================================================
// far-side port model: answers each analog stage after a set delay
module dpdm_stage_model (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 stage_req,
   input  wire logic [2:0]           stage_sel,
   input  wire logic [4:0]           dly,
   input  wire logic [2:0]           pri_cls,
   input  wire logic                 sec_dcp,
   input  wire logic                 hv12_ok,
   input  wire logic                 hv9_ok,
   output dpdm_pkg::dpdm_stage_type  stage_result
);
   import dpdm_pkg::*;
   logic [5:0] cnt_r;
   logic [2:0] sel_r;
   logic       hit;
   logic       ok_sel;
   // a stage ends once it has been held for the chosen delay
   assign hit    = stage_req && (stage_sel == sel_r) && (cnt_r == {1'b0, dly});
   // a charging downstream answer is final here; enumerating it in time is left to the host side
   assign ok_sel = (stage_sel == 3'h3) ? sec_dcp : (stage_sel == 3'h4) ? hv12_ok : hv9_ok;
   // between results the lines wander, so a stale answer is never read as valid
   assign stage_result = hit ? {1'b1, ok_sel, pri_cls} : {1'b0, cnt_r[3], cnt_r[2:0]};
   // delay counter restarts on every new stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 6'h00;
         sel_r <= 3'h0;
      end else begin
         cnt_r <= (!stage_req || stage_sel != sel_r) ? 6'h00 : cnt_r + 6'h01;
         sel_r <= stage_sel;
      end
   end
endmodule // dpdm_stage_model

/* testbench/dpdm_source_type_detector_tb.sv */
`timescale 1ns/100ps
module dpdm_source_type_detector_tb;
   import dpdm_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic        CLK = 1'b0, NRST = 1'b0, SOURCE_QUALIFIED = 1'b0, AUTO_DETECT_ENABLE = 1'b1;
   logic        DETECT_COMPLETE_FLAG_CLR = 1'b0, ILIM_WR = 1'b0, DRIVE_WR = 1'b0, FET_ENABLE_WR = 1'b0;
   logic        POWER_ON_SENSE = 1'b0, FET_PAIR1_SENSE = 1'b0, FET_PAIR2_SENSE = 1'b0;
   logic [11:0] ILIM_WDATA = 12'h000;
   logic [2:0]  DP_LEVEL_WDATA = 3'h0, DM_LEVEL_WDATA = 3'h0;
   logic [7:0]  DP_ADC_IN = 8'h00, DM_ADC_IN = 8'h00;
   logic [1:0]  FET_ENABLE_WDATA = 2'h0;
   logic [14:0] cfg = 15'h0000;   // mask,hv,req9,req12,ok12,ok9,dcp,pri[2:0],dly[4:0]
   logic        DETECT_RUNNING_STATUS, DETECT_COMPLETE_FLAG, IRQ_N, STAGE_REQ;
   logic        FET_PAIR1_PRESENT, FET_PAIR2_PRESENT, FET_PAIR1_ENABLE, FET_PAIR2_ENABLE;
   logic [3:0]  SOURCE_TYPE_CODE;
   logic [11:0] INPUT_CURRENT_LIMIT;
   logic [2:0]  STAGE_SEL, DP_DRIVE_LEVEL, DM_DRIVE_LEVEL;
   logic [7:0]  DP_ADC_VALUE, DM_ADC_VALUE;
   dpdm_stage_type STAGE_RESULT;
   logic [2:0]  seq[$];
   int          miscompares = 0, checks_done = 0, irq_cnt = 0, cycles = 0;
   bit          hv_seen;
   logic [14:0] c;
   // dcp with both requests (12 V fails, then passes), enable off, no requests, cdp
   logic [14:0] c_list[5] = '{15'h3b23, 15'h7f23, 15'h1b23, 15'h2723, 15'h0023};

   dpdm_detect dpdm_detect_i (.CLK(CLK), .NRST(NRST), .SOURCE_QUALIFIED(SOURCE_QUALIFIED),
      .AUTO_DETECT_ENABLE(AUTO_DETECT_ENABLE), .HV_ADAPTER_ENABLE(cfg[13]), .REQUEST_9V_ENABLE(cfg[12]),
      .REQUEST_12V_ENABLE(cfg[11]), .DETECT_COMPLETE_IRQ_MASK(cfg[14]),
      .DETECT_COMPLETE_FLAG_CLR(DETECT_COMPLETE_FLAG_CLR), .DETECT_RUNNING_STATUS(DETECT_RUNNING_STATUS),
      .DETECT_COMPLETE_FLAG(DETECT_COMPLETE_FLAG), .IRQ_N(IRQ_N), .SOURCE_TYPE_CODE(SOURCE_TYPE_CODE),
      .INPUT_CURRENT_LIMIT(INPUT_CURRENT_LIMIT), .ILIM_WR(ILIM_WR), .ILIM_WDATA(ILIM_WDATA),
      .STAGE_REQ(STAGE_REQ), .STAGE_SEL(STAGE_SEL), .STAGE_RESULT(STAGE_RESULT), .DRIVE_WR(DRIVE_WR),
      .DP_LEVEL_WDATA(DP_LEVEL_WDATA), .DM_LEVEL_WDATA(DM_LEVEL_WDATA), .DP_DRIVE_LEVEL(DP_DRIVE_LEVEL),
      .DM_DRIVE_LEVEL(DM_DRIVE_LEVEL), .DP_ADC_IN(DP_ADC_IN), .DM_ADC_IN(DM_ADC_IN),
      .DP_ADC_VALUE(DP_ADC_VALUE), .DM_ADC_VALUE(DM_ADC_VALUE), .POWER_ON_SENSE(POWER_ON_SENSE),
      .FET_PAIR1_SENSE(FET_PAIR1_SENSE), .FET_PAIR2_SENSE(FET_PAIR2_SENSE),
      .FET_PAIR1_PRESENT(FET_PAIR1_PRESENT), .FET_PAIR2_PRESENT(FET_PAIR2_PRESENT),
      .FET_ENABLE_WR(FET_ENABLE_WR), .FET_ENABLE_WDATA(FET_ENABLE_WDATA),
      .FET_PAIR1_ENABLE(FET_PAIR1_ENABLE), .FET_PAIR2_ENABLE(FET_PAIR2_ENABLE));

   dpdm_stage_model dpdm_stage_model_i (.clk(CLK), .nrst(NRST), .stage_req(STAGE_REQ),
      .stage_sel(STAGE_SEL), .dly(cfg[4:0]), .pri_cls(cfg[7:5]), .sec_dcp(cfg[8]), .hv12_ok(cfg[10]),
      .hv9_ok(cfg[9]), .stage_result(STAGE_RESULT));

   // ==========================================================
   // clock, monitors and hang guard
   always #5 CLK = ~CLK;
   always @(posedge CLK) begin
      if (STAGE_REQ && STAGE_RESULT.done) seq.push_back(STAGE_SEL);
      if (IRQ_N === 1'b0) irq_cnt++;
      if (STAGE_REQ && STAGE_SEL >= 3'h4 && !hv_seen) begin
         hv_seen = 1;
         chk("limit before handshake", ILIM_DCP, INPUT_CURRENT_LIMIT);
      end
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   // ==========================================================
   // checking helpers
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic logic [15:0] expect_result(input logic [14:0] k);
      logic [15:0] r;
      r = {TYPE_UNK, ILIM_UNK};
      case (k[7:5])
         PRI_SDP:  r = {TYPE_SDP, ILIM_SDP};
         PRI_DIV1: r = {TYPE_NSTD, ILIM_DIV1};
         PRI_DIV2: r = {TYPE_NSTD, ILIM_DIV2};
         PRI_DIV3: r = {TYPE_NSTD, ILIM_DIV3};
         PRI_DIV4: r = {TYPE_NSTD, ILIM_DIV4};
         PRI_PORT: begin
            r = k[8] ? {TYPE_DCP, ILIM_DCP} : {TYPE_CDP, ILIM_CDP};
            if (k[8] && k[13] && ((k[11] && k[10]) || (k[12] && k[9]))) r = {TYPE_HV, ILIM_HV};
         end
         default: ;
      endcase
      return r;
   endfunction

   // ==========================================================
   // insertion and detection runs
   task automatic insert(input logic [14:0] k);
      @(posedge CLK);
      SOURCE_QUALIFIED <= 1'b0;
      DETECT_COMPLETE_FLAG_CLR <= 1'b1;
      cfg <= k;
      @(posedge CLK);
      DETECT_COMPLETE_FLAG_CLR <= 1'b0;
      repeat (5) @(posedge CLK);
      seq.delete();
      irq_cnt = 0;
      hv_seen = 0;
      SOURCE_QUALIFIED <= 1'b1;
   endtask

   task automatic wait_done;
      int n;
      n = 0;
      while (DETECT_COMPLETE_FLAG !== 1'b1 && n < 3000) begin
         @(posedge CLK);
         n++;
      end
      repeat (3) @(posedge CLK);
   endtask

   task automatic run_det(input logic [14:0] k);
      logic [15:0] er;
      logic [2:0]  eq[$];
      bit          dh;
      eq = '{3'h1, 3'h2};
      dh = k[7:5] == PRI_PORT && k[8] && k[13];
      if (k[7:5] == PRI_PORT) eq.push_back(3'h3);
      if (dh && k[11]) eq.push_back(3'h4);
      if (dh && k[12] && !(k[11] && k[10])) eq.push_back(3'h5);
      er = expect_result(k);
      insert(k);
      wait_done();
      chk("flag", 12'h001, DETECT_COMPLETE_FLAG);
      chk("running", 12'h000, DETECT_RUNNING_STATUS);
      chk("irq pulses", k[14] ? 12'h000 : 12'h001, 12'(irq_cnt));
      chk("type", 12'(er[15:12]), 12'(SOURCE_TYPE_CODE));
      chk("limit", er[11:0], INPUT_CURRENT_LIMIT);
      chk("stage count", 12'(eq.size()), 12'(seq.size()));
      foreach (eq[i]) chk("stage order", eq[i], (i < seq.size()) ? seq[i] : 3'h0);
   endtask

   task automatic fet_case(input logic [1:0] sense, input logic [1:0] wd, input logic [1:0] en);
      if ({FET_PAIR2_PRESENT, FET_PAIR1_PRESENT} !== sense) begin
         @(posedge CLK);
         POWER_ON_SENSE <= 1'b0;
         {FET_PAIR2_SENSE, FET_PAIR1_SENSE} <= sense;
         repeat (4) @(posedge CLK);
         POWER_ON_SENSE <= 1'b1;
         repeat (5) @(posedge CLK);
      end
      chk("presence", sense, {FET_PAIR2_PRESENT, FET_PAIR1_PRESENT});
      FET_ENABLE_WR <= 1'b1;
      FET_ENABLE_WDATA <= wd;
      @(posedge CLK);
      FET_ENABLE_WR <= 1'b0;
      repeat (2) @(posedge CLK);
      chk("fet enables", en, {FET_PAIR2_ENABLE, FET_PAIR1_ENABLE});
   endtask

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'he88e));
      repeat (4) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      chk("reset limit", ILIM_RST, INPUT_CURRENT_LIMIT);
      fet_case(2'h3, 2'h1, 2'h1);
      fet_case(2'h3, 2'h3, 2'h1);
      fet_case(2'h3, 2'h2, 2'h2);
      fet_case(2'h1, 2'h3, 2'h1);
      fet_case(2'h0, 2'h3, 2'h0);
      repeat (4) begin
         DP_ADC_IN <= 8'($urandom);
         DM_ADC_IN <= 8'($urandom);
         repeat (5) @(posedge CLK);
         chk("dp adc", DP_ADC_IN, DP_ADC_VALUE);
         chk("dm adc", DM_ADC_IN, DM_ADC_VALUE);
      end
      // every primary class, then high-voltage corner cases
      for (int p = 0; p < 7; p++) run_det({p[0], 6'h00, p[2:0], 5'h02});
      foreach (c_list[i]) run_det(c_list[i]);
      repeat (12) begin
         c = 15'($urandom);
         c[7:5] = 3'($urandom_range(6, 0));
         run_det(c);
      end
      // host practice on a dedicated port: lower the limit, then enable high voltage, then clear it
      run_det(15'h1123);
      ILIM_WR <= 1'b1;
      ILIM_WDATA <= ILIM_HV;
      @(posedge CLK);
      ILIM_WR <= 1'b0;
      cfg[13] <= 1'b1;
      repeat (2) @(posedge CLK);
      chk("host limit", ILIM_HV, INPUT_CURRENT_LIMIT);
      cfg[13] <= 1'b0;
      // detection switched off keeps the host limit
      AUTO_DETECT_ENABLE <= 1'b0;
      ILIM_WR <= 1'b1;
      ILIM_WDATA <= 12'h4d2;
      @(posedge CLK);
      ILIM_WR <= 1'b0;
      insert(15'h0022);
      repeat (40) @(posedge CLK);
      chk("limit kept", 12'h4d2, INPUT_CURRENT_LIMIT);
      chk("no stages", 12'h000, 12'(seq.size()));
      AUTO_DETECT_ENABLE <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge CLK);
         DRIVE_WR <= 1'b1;
         DP_LEVEL_WDATA <= 3'(i);
         DM_LEVEL_WDATA <= 3'(i);
         @(posedge CLK);
         DRIVE_WR <= 1'b0;
         repeat (2) @(posedge CLK);
         chk("dp level", 12'(i), DP_DRIVE_LEVEL);
         chk("dm level", (i == 1 || i == 7) ? 12'h000 : 12'(i), DM_DRIVE_LEVEL);
      end
      // writes refused mid-detection, then a reinsertion restarts
      // twelve-cycle stages (delay 10): the reinsertion lands in the primary stage
      insert(15'h000a);
      repeat (10) @(posedge CLK);
      chk("running", 12'h001, DETECT_RUNNING_STATUS);
      DRIVE_WR <= 1'b1;
      DP_LEVEL_WDATA <= 3'h3;
      DM_LEVEL_WDATA <= 3'h3;
      ILIM_WR <= 1'b1;
      ILIM_WDATA <= 12'h123;
      @(posedge CLK);
      DRIVE_WR <= 1'b0;
      ILIM_WR <= 1'b0;
      repeat (2) @(posedge CLK);
      chk("dp locked", 12'h007, DP_DRIVE_LEVEL);
      chk("dm locked", 12'h000, DM_DRIVE_LEVEL);
      chk("limit locked", 12'h4d2, INPUT_CURRENT_LIMIT);
      SOURCE_QUALIFIED <= 1'b0;
      repeat (4) @(posedge CLK);
      SOURCE_QUALIFIED <= 1'b1;
      seq.delete();
      wait_done();
      chk("restart stages", 12'h002, 12'(seq.size()));
      chk("restart first", 12'h001, seq[0]);
      chk("restart type", TYPE_SDP, SOURCE_TYPE_CODE);
      wrap_up();
   end

endmodule // dpdm_source_type_detector_tb
